// ==== design/pin_irq_pkg.sv ====
// Package with register map, field positions and reset values of the pin interrupt latch.
package pin_irq_pkg;
    // Byte offsets on the register bus.
    localparam logic [3:0] STATUS_CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] BREAK_CONTROL_OFFSET  = 4'h4;
    localparam logic [3:0] VECTOR_OFFSET         = 4'h8;
    // Field positions in the status and control register.
    localparam int MODE_BIT    = 0;
    localparam int MASK_BIT    = 1;
    localparam int ACK_BIT     = 2;
    localparam int PENDING_BIT = 3;
    localparam int PIN_BIT     = 4;
    // Field position in the break control register.
    localparam int BCE_BIT     = 0;
    // Reset values.
    localparam logic RESET_MODE = 1'b0;
    localparam logic RESET_MASK = 1'b0;
    localparam logic RESET_BCE  = 1'b0;
    // Vector addresses fetched for this interrupt, high byte first.
    localparam logic [15:0] VECTOR_HIGH_ADDR = 16'hFFFA;
    localparam logic [15:0] VECTOR_LOW_ADDR  = 16'hFFFB;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== design/pin_sync.sv ====
// Three-stage synchroniser for the external interrupt pin with agreement detection.
`timescale 1ns/1ps
module pin_sync (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      fall_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic lvl_nxt;

    // The level changes only once the second and third stages agree.
    always_comb begin
        lvl_nxt = lvl_r;
        if (s2_r == s3_r) begin
            lvl_nxt = s3_r;
        end
    end

    // Sampling chain; the pin idles high so every stage resets high.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s1_r  <= 1'b1;
            s2_r  <= 1'b1;
            s3_r  <= 1'b1;
            lvl_r <= 1'b1;
        end else begin
            s1_r  <= pin_in;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    // Edge compares consecutive settled samples. [R18]
    assign level_out = lvl_r;
    assign fall_out  = lvl_r & ~lvl_nxt;
endmodule

// ==== design/pin_irq_latch.sv ====
// External active-low pin interrupt latch with AXI4-Lite register access.
// Behaviour
// R01 - A falling edge on the pin sets the interrupt latch and raises a request.
// R02 - A vector fetch acknowledge clears the latch without software action.
// R03 - Writing one to the acknowledge bit clears the latch like a vector fetch.
// R04 - System reset clears the interrupt latch unconditionally.
// R05 - Out of reset edge only; select bit chooses edge or edge plus low level.
// R06 - Edge mode: request persists until acknowledge or reset; acknowledge clears at once.
// R07 - Level mode: request holds until acknowledged and pin high, either order.
// R08 - Reset clears latch and select bit even with the pin held low.
// R09 - Mask bit set withholds the request from the priority logic.
// R10 - Acknowledge does not block later edges; a new edge latches again.
// R11 - Unmasked request taken makes the CPU fetch vector at FFFA then FFFB.
// R12 - Pending flag shows the latch regardless of the mask bit.
// R13 - Current pin level is offered to the branch-on-pin-level instructions.
// R14 - Software should mask requests inside a level-mode service routine.
// R15 - Acknowledge bit is write-only, reads zero, cleared by reset.
// R16 - Mask bit is read/write, one disables requests, reset clears it.
// R17 - In break, acknowledge writes act only with break clear enable set.
// R18 - Pin is synchronised before edge and level detection.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module pin_irq_latch (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        irq_pin_n,
    input  wire logic        vector_fetch_ack,
    input  wire logic        break_state,
    output logic             irq_request,
    output logic             pin_level,
    output logic [15:0]      vector_high_addr,
    output logic [15:0]      vector_low_addr,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser.
    logic pin_sync_level;
    logic pin_fall;

    pin_sync u_pin_sync (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .pin_in    (irq_pin_n),
        .level_out (pin_sync_level),
        .fall_out  (pin_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write channel state.
    logic        aw_held_r;
    logic        aw_held_nxt;
    logic [3:0]  aw_addr_r;
    logic [3:0]  aw_addr_nxt;
    logic        w_held_r;
    logic        w_held_nxt;
    logic [31:0] w_data_r;
    logic [31:0] w_data_nxt;
    logic [3:0]  w_strb_r;
    logic [3:0]  w_strb_nxt;
    logic        bvalid_r;
    logic        bvalid_nxt;
    logic [1:0]  bresp_r;
    logic [1:0]  bresp_nxt;
    logic        wr_fire;
    logic        aw_take;
    logic        w_take;

    // Register state.
    logic mode_r;
    logic mode_nxt;
    logic mask_r;
    logic mask_nxt;
    logic bce_r;
    logic bce_nxt;
    logic latch_r;
    logic latch_nxt;
    logic ack_pending_r;
    logic ack_pending_nxt;
    logic ack_seen_r;
    logic ack_seen_nxt;
    logic soft_ack;
    logic any_ack;

    // Read channel state.
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0]  rresp_r;
    logic [1:0]  rresp_nxt;

    // Low byte written with its strobe decides a field write.
    function automatic logic low_byte_hit(input logic [3:0] addr, input logic [3:0] strb,
                                          input logic [3:0] target);
        low_byte_hit = (addr == target) && strb[0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address and data are taken in either order; response after both.
    // The fire term looks only at registers and bus inputs, so it never
    // feeds back through the next-state logic that it controls.
    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready  = ~w_held_r & ~bvalid_r;
    assign aw_take       = s_axi_awvalid & s_axi_awready;
    assign w_take        = s_axi_wvalid & s_axi_wready;
    assign wr_fire       = (aw_held_r | aw_take) & (w_held_r | w_take) & ~bvalid_r;

    always_comb begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt  = w_held_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            if (aw_addr_nxt == pin_irq_pkg::STATUS_CONTROL_OFFSET) begin
                bresp_nxt = pin_irq_pkg::RESP_OKAY;
            end else if (aw_addr_nxt == pin_irq_pkg::BREAK_CONTROL_OFFSET) begin
                bresp_nxt = pin_irq_pkg::RESP_OKAY;
            end else if (aw_addr_nxt == pin_irq_pkg::VECTOR_OFFSET) begin
                bresp_nxt = pin_irq_pkg::RESP_OKAY;
            end else begin
                bresp_nxt = pin_irq_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= pin_irq_pkg::RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r  <= w_held_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    ////////////////////////////////////////////////////////////////////////////
    // Control register writes; the acknowledge bit is a one-cycle strobe only.
    always_comb begin
        mode_nxt        = mode_r;
        mask_nxt        = mask_r;
        bce_nxt         = bce_r;
        ack_pending_nxt = 1'b0;
        if (wr_fire && low_byte_hit(aw_addr_nxt, w_strb_nxt,
                                    pin_irq_pkg::STATUS_CONTROL_OFFSET)) begin
            mode_nxt        = w_data_nxt[pin_irq_pkg::MODE_BIT]; // [R05]
            mask_nxt        = w_data_nxt[pin_irq_pkg::MASK_BIT]; // [R16]
            ack_pending_nxt = w_data_nxt[pin_irq_pkg::ACK_BIT];  // [R03] [R15]
        end
        if (wr_fire && low_byte_hit(aw_addr_nxt, w_strb_nxt,
                                    pin_irq_pkg::BREAK_CONTROL_OFFSET)) begin
            bce_nxt = w_data_nxt[pin_irq_pkg::BCE_BIT];
        end
    end

    // Acknowledge from software is blocked in break unless enabled. [R17]
    assign soft_ack = ack_pending_r & (~break_state | bce_r);
    assign any_ack  = soft_ack | vector_fetch_ack; // [R02] [R03]

    // Latch: edge sets and wins over acknowledge; level mode holds while low.
    // An acknowledge taken while the pin is low in level mode is remembered,
    // so the request drops as soon as the pin returns high, in either order.
    always_comb begin
        latch_nxt    = latch_r;
        ack_seen_nxt = mode_r & ~pin_sync_level & (ack_seen_r | any_ack); // [R07]
        if (any_ack) begin
            latch_nxt = 1'b0; // [R06]
        end
        if (mode_r && !pin_sync_level) begin
            latch_nxt = 1'b1; // [R07]
        end
        if (ack_seen_r && pin_sync_level) begin
            latch_nxt = 1'b0; // [R07]
        end
        if (pin_fall) begin
            latch_nxt = 1'b1; // [R01] [R10]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_r        <= pin_irq_pkg::RESET_MODE; // [R05] [R08]
            mask_r        <= pin_irq_pkg::RESET_MASK; // [R16]
            bce_r         <= pin_irq_pkg::RESET_BCE;
            latch_r       <= 1'b0;                    // [R04] [R08]
            ack_pending_r <= 1'b0;                    // [R15]
            ack_seen_r    <= 1'b0;
        end else begin
            mode_r        <= mode_nxt;
            mask_r        <= mask_nxt;
            bce_r         <= bce_nxt;
            latch_r       <= latch_nxt;
            ack_pending_r <= ack_pending_nxt;
            ack_seen_r    <= ack_seen_nxt;
        end
    end

    // Request is withheld while masked; pin level and vectors go to the CPU.
    assign irq_request      = latch_r & ~mask_r;                // [R09]
    assign pin_level        = pin_sync_level;                   // [R13]
    assign vector_high_addr = pin_irq_pkg::VECTOR_HIGH_ADDR;    // [R11]
    assign vector_low_addr  = pin_irq_pkg::VECTOR_LOW_ADDR;     // [R11]

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one-cycle answer, pending flag ignores the mask.
    assign s_axi_arready = ~rvalid_r;

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = 32'h0000_0000;
            rresp_nxt  = pin_irq_pkg::RESP_OKAY;
            if (s_axi_araddr == pin_irq_pkg::STATUS_CONTROL_OFFSET) begin
                rdata_nxt[pin_irq_pkg::MODE_BIT]    = mode_r;
                rdata_nxt[pin_irq_pkg::MASK_BIT]    = mask_r;
                rdata_nxt[pin_irq_pkg::PENDING_BIT] = latch_r;        // [R12]
                rdata_nxt[pin_irq_pkg::PIN_BIT]     = pin_sync_level; // [R13]
            end else if (s_axi_araddr == pin_irq_pkg::BREAK_CONTROL_OFFSET) begin
                rdata_nxt[pin_irq_pkg::BCE_BIT] = bce_r;
            end else if (s_axi_araddr == pin_irq_pkg::VECTOR_OFFSET) begin
                rdata_nxt = {pin_irq_pkg::VECTOR_HIGH_ADDR, pin_irq_pkg::VECTOR_LOW_ADDR};
            end else begin
                rresp_nxt = pin_irq_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= pin_irq_pkg::RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_fall_sets_latch: assert property (pin_fall |=> latch_r) // [R01]
        else $error("Falling edge did not set latch.");
    a_vector_ack_clear: assert property ( // [R02]
        vector_fetch_ack && !pin_fall && !mode_r |=> !latch_r)
        else $error("Vector acknowledge did not clear latch.");
    a_soft_ack_clear: assert property ( // [R03]
        soft_ack && !pin_fall && !mode_r |=> !latch_r)
        else $error("Software acknowledge did not clear latch.");
    a_reset_clears: assert property (disable iff (1'b0) srst |=> !latch_r && !mode_r) // [R08]
        else $error("Reset left latch or mode set.");
    a_edge_persist: assert property (latch_r && !any_ack && !ack_seen_r |=> latch_r) // [R06]
        else $error("Latch dropped without acknowledge.");
    a_level_hold: assert property (mode_r && !pin_sync_level |=> latch_r) // [R07]
        else $error("Level mode released latch while pin low.");
    a_mask_gates: assert property (irq_request == (latch_r && !mask_r)) // [R09]
        else $error("Request does not follow latch and mask.");
    a_break_block: assert property ( // [R17]
        ack_pending_r && break_state && !bce_r && !vector_fetch_ack && !ack_seen_r
        && latch_r |=> latch_r)
        else $error("Acknowledge in break cleared latch.");
    a_ack_reads_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[pin_irq_pkg::ACK_BIT]) // [R15]
        else $error("Acknowledge bit read as one.");

    // Level-mode deferred acknowledge, status read-back, strobe width and reset of mask and break clear enable.
    a_deferred_ack: assert property ( // [R07]
        ack_seen_r && pin_sync_level && !pin_fall |=> !latch_r)
        else $error("Level mode kept latch after acknowledge and pin high.");
    a_pending_read: assert property ( // [R12]
        s_axi_arvalid && s_axi_arready
        && s_axi_araddr == pin_irq_pkg::STATUS_CONTROL_OFFSET
        |=> s_axi_rdata[pin_irq_pkg::PENDING_BIT] == $past(latch_r))
        else $error("Pending flag read back wrong.");
    a_pin_read: assert property ( // [R13]
        s_axi_arvalid && s_axi_arready
        && s_axi_araddr == pin_irq_pkg::STATUS_CONTROL_OFFSET
        |=> s_axi_rdata[pin_irq_pkg::PIN_BIT] == $past(pin_sync_level))
        else $error("Pin level read back wrong.");
    a_ack_one_cycle: assert property (ack_pending_r |=> !ack_pending_r) // [R15]
        else $error("Acknowledge strobe lasted more than one cycle.");
    a_reset_mask: assert property (disable iff (1'b0) srst |=> !mask_r && !bce_r) // [R16]
        else $error("Reset left mask or break clear enable set.");

    c_edge_request: cover property (pin_fall ##1 irq_request);
    c_deferred_ack: cover property (ack_seen_r && pin_sync_level);
    c_level_ack: cover property (mode_r && latch_r && any_ack && !pin_sync_level);
    c_masked_pending: cover property (latch_r && mask_r);
    c_break_ack: cover property (ack_pending_r && break_state);
endmodule

// ==== verif/irq_source.sv ====
// Model of the external interrupt source that drives the active-low pin.
`timescale 1ns/1ps
module irq_source (
    input  wire logic drive_low,
    output logic      irq_pin_n
);
    // A released pin is pulled up, so it reads high and never floats.
    assign irq_pin_n = drive_low ? 1'b0 : 1'b1;
endmodule

// ==== verif/tb_top.sv ====
// Self-checking testbench for the external pin interrupt latch.
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys;
    logic        srst;
    logic        drive_low;
    logic        irq_pin_n;
    logic        vector_fetch_ack;
    logic        break_state;
    logic        irq_request;
    logic        pin_level;
    logic [15:0] vec_hi;
    logic [15:0] vec_lo;
    logic [3:0]  awaddr;
    logic [3:0]  araddr;
    logic [3:0]  wstrb;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] rd;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [1:0]  resp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          miscompares;
    int          checked;
    int          cycles;

    ////////////////////////////////////////////////////////////
    // Pin source and design under test.
    irq_source src (.drive_low(drive_low), .irq_pin_n(irq_pin_n));
    pin_irq_latch DUT (
        .clk_sys(clk_sys), .srst(srst), .irq_pin_n(irq_pin_n),
        .vector_fetch_ack(vector_fetch_ack), .break_state(break_state),
        .irq_request(irq_request), .pin_level(pin_level),
        .vector_high_addr(vec_hi), .vector_low_addr(vec_lo),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    // The clock toggles every half period of 5 ns.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // A hung handshake is cut short well beyond the expected run length.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////
    // Compares a value with its expectation and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Write cycle; handshakes are judged at the falling edge before the taking edge.
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        logic ta;
        logic tw;
        logic tb;
        @(posedge clk_sys);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            resp = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
    endtask

    // Read cycle; data and response are taken at the edge where rvalid is seen.
    task automatic reg_read(input logic [3:0] a);
        logic tr;
        logic tv;
        @(posedge clk_sys);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge clk_sys);
            tr = arvalid && arready;
            tv = rvalid;
            rd = rdata;
            resp = rresp;
            @(posedge clk_sys);
            if (tr) arvalid <= 1'b0;
        end while (!tv);
        rready <= 1'b0;
    endtask

    // Reads a register and compares the whole word.
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        reg_read(a);
        check(rd, e);
    endtask

    // Moves the pin and waits past the synchroniser and latch delay.
    task automatic pin(input logic low);
        @(posedge clk_sys);
        drive_low <= low;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence: map 0x0 status/control, 0x4 break control, 0x8 vector.
    initial begin
        srst = 1'b1;
        drive_low = 1'b0;
        vector_fetch_ack = 1'b0;
        break_state = 1'b0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {miscompares, checked} = '0;
        wstrb = 4'hF;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        rd_chk(4'h0, 32'h0000_0010);
        rd_chk(4'h4, 32'h0000_0000);
        rd_chk(4'h8, 32'hFFFA_FFFB);
        check({vec_hi, vec_lo}, 32'hFFFA_FFFB);
        reg_read(4'hC);
        check({30'h0, resp}, {30'h0, pin_irq_pkg::RESP_SLVERR});
        reg_write(4'hC, 32'h0000_0001);
        check({30'h0, resp}, {30'h0, pin_irq_pkg::RESP_SLVERR});
        // Edge mode: latch, hold after the pin rises, software acknowledge.
        pin(1'b1);
        check({31'h0, irq_request}, 32'h1);
        check({31'h0, pin_level}, 32'h0);
        rd_chk(4'h0, 32'h0000_0008);
        pin(1'b0);
        rd_chk(4'h0, 32'h0000_0018);
        reg_write(4'h0, 32'h0000_0004);
        rd_chk(4'h0, 32'h0000_0010);
        // A fresh edge after the acknowledge latches; a vector fetch clears it.
        pin(1'b1);
        check({31'h0, irq_request}, 32'h1);
        @(posedge clk_sys);
        vector_fetch_ack <= 1'b1;
        @(posedge clk_sys);
        vector_fetch_ack <= 1'b0;
        pin(1'b1);
        check({31'h0, irq_request}, 32'h0);
        pin(1'b0);
        // Mask withholds the request but not the pending flag.
        @(posedge clk_sys);
        wstrb <= 4'hE;
        reg_write(4'h0, 32'h0000_0002);
        wstrb <= 4'hF;
        rd_chk(4'h0, 32'h0000_0010);
        reg_write(4'h0, 32'h0000_0002);
        rd_chk(4'h0, 32'h0000_0012);
        pin(1'b1);
        check({31'h0, irq_request}, 32'h0);
        rd_chk(4'h0, 32'h0000_000A);
        reg_write(4'h0, 32'h0000_0000);
        @(negedge clk_sys);
        check({31'h0, irq_request}, 32'h1);
        reg_write(4'h0, 32'h0000_0004);
        pin(1'b0);
        // Level mode: acknowledge while low, then pin high; then the other order.
        reg_write(4'h0, 32'h0000_0001);
        pin(1'b1);
        reg_write(4'h0, 32'h0000_0007);
        @(negedge clk_sys);
        check({31'h0, irq_request}, 32'h0);
        rd_chk(4'h0, 32'h0000_000B);
        pin(1'b0);
        rd_chk(4'h0, 32'h0000_0013);
        reg_write(4'h0, 32'h0000_0001);
        pin(1'b1);
        pin(1'b0);
        check({31'h0, irq_request}, 32'h1);
        rd_chk(4'h0, 32'h0000_0019);
        reg_write(4'h0, 32'h0000_0005);
        rd_chk(4'h0, 32'h0000_0011);
        // Reset with the pin low in level mode drops the request and the mode.
        pin(1'b1);
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        check({31'h0, irq_request}, 32'h0);
        @(posedge clk_sys);
        srst <= 1'b0;
        pin(1'b1);
        reg_read(4'h0);
        check(rd & 32'h0000_0017, 32'h0000_0000);
        pin(1'b0);
        reg_write(4'h0, 32'h0000_0004);
        // In break the acknowledge acts only with break clear enable set.
        pin(1'b1);
        pin(1'b0);
        @(posedge clk_sys);
        break_state <= 1'b1;
        reg_write(4'h0, 32'h0000_0004);
        rd_chk(4'h0, 32'h0000_0018);
        reg_write(4'h4, 32'h0000_0001);
        rd_chk(4'h4, 32'h0000_0001);
        reg_write(4'h0, 32'h0000_0004);
        rd_chk(4'h0, 32'h0000_0010);
        @(posedge clk_sys);
        break_state <= 1'b0;
        rd_chk(4'h0, 32'h0000_0010);
        wrap_up();
    end
endmodule
